// File: bench/boot_strap_mode_sleep_control_tb.sv
// self-checking bench for the strap, mode and sleep controller
`timescale 1ns/1ps
`include "bsms_regs.svh"
module boot_strap_mode_sleep_control_tb import bsms_pkg::*; ;
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic [5:0] pin_in, pin_cfg_dir, pin_cfg_pu, pin_cfg_pd, pin_cfg_out;
	bsms_boot_mode_t boot_mode;
	logic iface_found, fw_loaded, pdm_clk_seen, cmd_swpt, cmd_hwpt;
	logic cmd_sleep, cmd_sleep_kind, cmd_sync, wake, sync_ack_read;
	logic primary_mic_input_port, pdm_data_out, pdm_clk, i2s_ws, i2s_bclk;
	logic i2s_sdo, i2c_scl_oe, i2c_sda_oe, uart_tx, host_irq, spi_miso;
	logic spi_miso_oe, boot_clock_strap, straps_valid, in_bootloader;
	logic autodetect, sw_passthru, hw_passthru, sleeping, sleep_kind;
	logic mem_retain, blocks_restart, sync_ack, mic_to_pcm, sleep_ok;
	logic passthrough_bitstream_output, host_go;
	logic [6:0] slave_addr;
	bsms_state_t state;
	logic [5:0] pin_out, pin_oe, pin_pu, pin_pd, p;
	logic [31:0] seed = 32'h00000001;
	logic [6:0] addr_tab [4] = '{7'h3E, 7'h38, 7'h3F, 7'h39};
	int error_cnt = 0;
	int checks_done = 0;
	int k;
	always #20 core_clk = ~core_clk;
	bsms_ctrl #(.NPINS(6)) dut (.core_clk, .sys_rst, .pin_in, .boot_mode,
		.iface_found, .fw_loaded, .pdm_clk_seen, .cmd_swpt, .cmd_hwpt,
		.cmd_sleep, .cmd_sleep_kind, .cmd_sync, .wake, .sync_ack_read,
		.pin_cfg_dir, .pin_cfg_pu, .pin_cfg_pd, .pin_cfg_out,
		.primary_mic_input_port, .pdm_data_out, .pdm_clk, .i2s_ws,
		.i2s_bclk, .i2s_sdo, .i2c_scl_oe, .i2c_sda_oe, .uart_tx, .host_irq,
		.spi_miso, .spi_miso_oe, .boot_clock_strap, .slave_addr,
		.straps_valid, .state, .in_bootloader, .autodetect, .sw_passthru,
		.hw_passthru, .sleeping, .sleep_kind, .mem_retain, .blocks_restart,
		.sync_ack, .passthrough_bitstream_output, .mic_to_pcm, .pin_out,
		.pin_oe, .pin_pu, .pin_pd);
	bsms_host_model #(.WAIT_CYC(20)) host (.core_clk, .go(host_go),
		.sync_ack, .wake, .cmd_sync, .sync_ack_read, .sleep_ok);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_val(ref logic s, input logic v);
		int i;
		for (i = 0; i < 200 && s !== v; i++) begin
			@(negedge core_clk);
		end
		if (s !== v) begin
			error_cnt++;
			stop_test();
		end
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask
	task automatic do_reset(input logic [5:0] pins);
		sys_rst = 1'h1;
		pin_in = pins;
		cyc(5);
		chk(pin_pd, 6'h3F);
		chk(pin_oe, 6'h00);
		chk(in_bootloader, 1'h1);
		sys_rst = 1'h0;
		cyc(3);
		chk(straps_valid, 1'h1);
		chk(state, BSMS_ST_AUTODET);
		chk(autodetect, 1'h1);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{iface_found, fw_loaded, pdm_clk_seen, cmd_swpt, cmd_hwpt} = 5'h00;
		{cmd_sleep, cmd_sleep_kind} = 2'h0;
		host_go <= 1'h0;
		{pin_cfg_dir, pin_cfg_pu, pin_cfg_pd, pin_cfg_out} = 24'h000000;
		{primary_mic_input_port, pdm_data_out, pdm_clk, i2s_ws, i2s_bclk,
			i2s_sdo, i2c_scl_oe, i2c_sda_oe, uart_tx, host_irq, spi_miso,
			spi_miso_oe} = 12'h000;
		boot_mode = BSMS_PDM_I2C;
		pin_in = 6'h00;
		@(negedge core_clk);
		// strap table, then pins change after capture
		for (k = 0; k < 4; k++) begin
			seed = xs(seed);
			p = {seed[5:4], k[0], k[1], k[1] ^ k[0], seed[0]};
			do_reset(p);
			chk(slave_addr, addr_tab[k]);
			chk(boot_clock_strap, p[1]);
			pin_in = ~p;
			cyc(3);
			chk(slave_addr, addr_tab[k]);
			chk(boot_clock_strap, p[1]);
		end
		// pdm clock in auto-detect enters bypass without firmware
		pdm_clk_seen = 1'h1;
		cyc(1);
		pdm_clk_seen = 1'h0;
		chk(state, BSMS_ST_HWPT);
		chk(hw_passthru, 1'h1);
		repeat (8) begin
			seed = xs(seed);
			{primary_mic_input_port, pdm_data_out, pdm_clk} = seed[2:0];
			cyc(1);
			chk(passthrough_bitstream_output, primary_mic_input_port);
		end
		do_reset(6'h00);
		chk(slave_addr, `BSMS_ADDR_00);
		iface_found = 1'h1;
		cyc(1);
		chk(state, BSMS_ST_IDLE);
		for (k = 0; k < 5; k++) begin
			seed = xs(seed);
			boot_mode = bsms_boot_mode_t'(k);
			{primary_mic_input_port, pdm_data_out, pdm_clk, i2s_ws, i2s_bclk,
				i2s_sdo, i2c_scl_oe, i2c_sda_oe, uart_tx, host_irq, spi_miso,
				spi_miso_oe} = seed[11:0];
			cyc(2);
			if (k < 3) begin
				chk(pin_out[1:0], {pdm_data_out, pdm_clk});
			end else begin
				chk(pin_out[3], i2s_sdo);
			end
			if (k == 0 || k == 3) begin
				chk(pin_oe[5], i2c_sda_oe);
			end
			if (k == 1 || k == 4) begin
				chk(pin_out[5], uart_tx);
			end
			if (k == 1) begin
				chk(pin_out[3], host_irq);
			end
			if (k == 2) begin
				chk(pin_out[3], spi_miso);
			end
		end
		pulse(cmd_sleep);
		chk(sleeping, 1'h0);
		pulse(cmd_swpt);
		chk(sw_passthru, 1'h0);
		fw_loaded = 1'h1;
		// both sleep kinds, each left through the wake sequence
		// third pass sleeps from bypass so wake must resume it
		for (k = 0; k < 3; k++) begin
			wait_val(sleep_ok, 1'h1);
			cmd_sleep_kind = k[0];
			if (k == 2) begin
				pulse(cmd_hwpt);
				chk(state, BSMS_ST_HWPT);
			end
			pulse(cmd_sleep);
			chk(state, BSMS_ST_SLEEP);
			chk(mem_retain, 1'h1);
			chk(sleep_kind, k[0]);
			chk(pin_oe, 6'h00);
			// nonblocking, so the host takes go on its next edge, no race
			host_go <= 1'h1;
			wait_val(sleeping, 1'h0);
			host_go <= 1'h0;
			chk(state, k == 2 ? BSMS_ST_HWPT : BSMS_ST_IDLE);
			chk(mem_retain, 1'h0);
			chk(blocks_restart, 1'h1);
			cyc(1);
			chk(blocks_restart, 1'h0);
			wait_val(sync_ack, 1'h1);
			cyc(1);
			chk(sync_ack, 1'h0);
		end
		pulse(cmd_swpt);
		chk(sw_passthru, 1'h1);
		chk(state, BSMS_ST_SWPT);
		chk(mic_to_pcm, 1'h1);
		seed = xs(seed);
		{pin_cfg_dir, pin_cfg_pu, pin_cfg_pd, pin_cfg_out} = seed[23:0];
		cyc(2);
		chk(pin_oe, pin_cfg_dir);
		chk(pin_pu, pin_cfg_pu);
		// pull-up wins where firmware asks for both
		chk(pin_pd, pin_cfg_pd & ~pin_cfg_pu);
		chk(pin_out, pin_cfg_out);
		stop_test();
	end
	// hang guard, far above the normal run length
	initial begin
		#2000000;
		error_cnt++;
		stop_test();
	end
endmodule // boot_strap_mode_sleep_control_tb

// File: bench/bsms_host_model.sv
// host model driving the wake line and the sync handshake
`timescale 1ns/1ps
module bsms_host_model #(
	parameter int WAIT_CYC = 20
) (
	input wire logic core_clk,
	input wire logic go,
	input wire logic sync_ack,
	output logic wake = 1'h0,
	output logic cmd_sync = 1'h0,
	output logic sync_ack_read = 1'h0,
	output logic sleep_ok
);
	// ****************************************
	// wake and sync sequence
	// ****************************************
	// 30 ms shrunk to WAIT_CYC cycles to keep the run short
	int cnt = 0;
	int ph = 0;
	always @(negedge core_clk) begin
		cmd_sync <= 1'h0;
		sync_ack_read <= 1'h0;
		cnt <= cnt + 1;
		case (ph)
			0: if (go) begin
				wake <= 1'h1;
				cnt <= 0;
				ph <= 1;
			end
			1: if (cnt >= WAIT_CYC) begin
				cmd_sync <= 1'h1;
				ph <= 2;
			end
			2: if (sync_ack === 1'h1) begin
				sync_ack_read <= 1'h1;
				ph <= 3;
			end
			default: begin
				wake <= 1'h0;
				cnt <= 0;
				ph <= 0;
			end
		endcase
	end
	assign sleep_ok = (ph == 0) && !wake && (cnt >= WAIT_CYC);
endmodule // bsms_host_model

// File: core/bsms_ctrl.sv
// boot strap latch, mode select and sleep sequencing top
//
// What this block does
// - software pass-through only after firmware; mic in, pcm/i2s out
// - hardware pass-through forwards primary mic bitstream to bypass output
// - retention sleep only after firmware; memory kept while asleep
// - wake signal leaves sleep; firmware resumes without new download
// - on wake, restart every block the sleep command switched off
// - use-case sleep behaves like retention sleep on its command
// - boot clock strap latched; 0 external clock, 1 internal oscillator
// - unconnected strap reads 0; 1 only when pulled up
// - two address straps latched and set the slave address
// - straps 00,01,10,11 give 0x3E,0x38,0x3F,0x39
// - after latch-on-reset come up in auto-detect, then await commands
// - while asleep do not drive the shared host buses
// - pdm+i2c pins: pdm clock, data, two straps, i2c clock, data
// - pdm+uart pins: pdm clock, data, unused, irq, rx, tx
// - pdm+spi pins: pdm clock, data, sclk, miso, select, mosi
// - i2s modes: ws, bclk, sdi, sdo, then i2c or uart
// - active mode firmware sets pin direction and pull per pin
// - after power-up sit in bootloader awaiting command or pdm clock
`timescale 1ns/1ps
`include "bsms_regs.svh"
module bsms_ctrl import bsms_pkg::*; #(
	parameter int NPINS = `BSMS_NPINS
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [NPINS-1:0] pin_in,
	input wire bsms_boot_mode_t boot_mode,
	input wire logic iface_found,
	input wire logic fw_loaded,
	input wire logic pdm_clk_seen,
	input wire logic cmd_swpt,
	input wire logic cmd_hwpt,
	input wire logic cmd_sleep,
	input wire logic cmd_sleep_kind,
	input wire logic cmd_sync,
	input wire logic wake,
	input wire logic sync_ack_read,
	input wire logic [NPINS-1:0] pin_cfg_dir,
	input wire logic [NPINS-1:0] pin_cfg_pu,
	input wire logic [NPINS-1:0] pin_cfg_pd,
	input wire logic [NPINS-1:0] pin_cfg_out,
	input wire logic primary_mic_input_port,
	input wire logic pdm_data_out,
	input wire logic pdm_clk,
	input wire logic i2s_ws,
	input wire logic i2s_bclk,
	input wire logic i2s_sdo,
	input wire logic i2c_scl_oe,
	input wire logic i2c_sda_oe,
	input wire logic uart_tx,
	input wire logic host_irq,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	output logic boot_clock_strap,
	output logic [6:0] slave_addr,
	output logic straps_valid,
	output bsms_state_t state,
	output logic in_bootloader,
	output logic autodetect,
	output logic sw_passthru,
	output logic hw_passthru,
	output logic sleeping,
	output logic sleep_kind,
	output logic mem_retain,
	output logic blocks_restart,
	output logic sync_ack,
	output logic passthrough_bitstream_output,
	output logic mic_to_pcm,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe,
	output logic [NPINS-1:0] pin_pu,
	output logic [NPINS-1:0] pin_pd
);
	// *************************************************
	// strap capture
	// *************************************************
	logic clk_strap;
	logic [1:0] addr_strap;
	logic clk_done;
	logic addr_done;
	// undriven straps see pull-down as 0 at the pin
	bsms_strap_latch #(.W(1)) u_clk_strap (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pin_in(pin_in[1]),
		.value(clk_strap),
		.done(clk_done)
	);
	// address straps on the third and fourth pin
	bsms_strap_latch #(.W(2)) u_addr_strap (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pin_in({pin_in[2], pin_in[3]}),
		.value(addr_strap),
		.done(addr_done)
	);
	logic [6:0] next_slave_addr;
	always_comb begin
		case (addr_strap)
			2'b00: next_slave_addr = `BSMS_ADDR_00;
			2'b01: next_slave_addr = `BSMS_ADDR_01;
			2'b10: next_slave_addr = `BSMS_ADDR_10;
			default: next_slave_addr = `BSMS_ADDR_11;
		endcase
	end
	// boot clock select held from strap
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			boot_clock_strap <= `BSMS_BOOT_EXT;
			slave_addr <= `BSMS_ADDR_RST;
			straps_valid <= 1'b0;
		end else begin
			boot_clock_strap <= clk_strap;
			slave_addr <= next_slave_addr;
			straps_valid <= clk_done & addr_done;
		end
	end
	// *************************************************
	// mode and sleep state machine
	// *************************************************
	bsms_state_t next_state;
	bsms_state_t resume_state;
	logic ready;
	assign ready = clk_done & addr_done;
	always_comb begin
		next_state = state;
		case (state)
			// leave boot into auto-detect after straps
			BSMS_ST_BOOT: if (ready) next_state = BSMS_ST_AUTODET;
			// bootloader waits for interface or pdm clock
			BSMS_ST_AUTODET: begin
				if (pdm_clk_seen) next_state = BSMS_ST_HWPT;
				else if (iface_found) next_state = BSMS_ST_IDLE;
			end
			BSMS_ST_IDLE: begin
				if (cmd_sleep && fw_loaded) next_state = BSMS_ST_SLEEP;
				else if (cmd_swpt && fw_loaded) next_state = BSMS_ST_SWPT;
				else if (cmd_hwpt) next_state = BSMS_ST_HWPT;
			end
			BSMS_ST_SWPT, BSMS_ST_HWPT: begin
				// sleep of either kind from an active use case
				if (cmd_sleep && fw_loaded) next_state = BSMS_ST_SLEEP;
				else if (cmd_hwpt && state == BSMS_ST_SWPT)
					next_state = BSMS_ST_HWPT;
				else if (cmd_swpt && fw_loaded) next_state = BSMS_ST_SWPT;
			end
			// wake returns to firmware mode, no reload
			BSMS_ST_SLEEP: if (wake) next_state = resume_state;
			default: next_state = BSMS_ST_BOOT;
		endcase
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= BSMS_ST_BOOT;
		end else begin
			state <= next_state;
		end
	end
	// remember the use case so wake resumes it
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			resume_state <= BSMS_ST_IDLE;
			sleep_kind <= `BSMS_SLEEP_RET;
		end else if (next_state == BSMS_ST_SLEEP && state != BSMS_ST_SLEEP) begin
			resume_state <= state;
			sleep_kind <= cmd_sleep_kind;
		end
	end
	// *************************************************
	// status outputs
	// *************************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_bootloader <= 1'b1;
			autodetect <= 1'b0;
			sw_passthru <= 1'b0;
			hw_passthru <= 1'b0;
			sleeping <= 1'b0;
			mem_retain <= 1'b0;
		end else begin
			in_bootloader <= next_state == BSMS_ST_BOOT ||
				next_state == BSMS_ST_AUTODET;
			autodetect <= next_state == BSMS_ST_AUTODET;
			sw_passthru <= next_state == BSMS_ST_SWPT;
			hw_passthru <= next_state == BSMS_ST_HWPT;
			sleeping <= next_state == BSMS_ST_SLEEP;
			mem_retain <= next_state == BSMS_ST_SLEEP;
		end
	end
	// one-cycle restart pulse on wake exit
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			blocks_restart <= 1'b0;
		end else begin
			blocks_restart <= state == BSMS_ST_SLEEP &&
				next_state != BSMS_ST_SLEEP;
		end
	end
	// sync acknowledge; host may then release wake
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_ack <= 1'b0;
		end else if (cmd_sync && state != BSMS_ST_SLEEP) begin
			sync_ack <= 1'b1;
		end else if (sync_ack_read) begin
			sync_ack <= 1'b0;
		end
	end
	// *************************************************
	// audio routing
	// *************************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			passthrough_bitstream_output <= 1'b0;
			mic_to_pcm <= 1'b0;
		end else begin
			passthrough_bitstream_output <= next_state == BSMS_ST_HWPT ?
				primary_mic_input_port : 1'b0;
			mic_to_pcm <= next_state == BSMS_ST_SWPT;
		end
	end
	// *************************************************
	// shared pins
	// *************************************************
	logic [NPINS-1:0] mux_out;
	logic [NPINS-1:0] mux_oe;
	bsms_pin_mux u_mux (
		.mode(boot_mode),
		.pdm_clk(pdm_clk),
		.pdm_data_out(pdm_data_out),
		.i2s_ws(i2s_ws),
		.i2s_bclk(i2s_bclk),
		.i2s_sdo(i2s_sdo),
		.i2c_scl_oe(i2c_scl_oe),
		.i2c_sda_oe(i2c_sda_oe),
		.uart_tx(uart_tx),
		.host_irq(host_irq),
		.spi_miso(spi_miso),
		.spi_miso_oe(spi_miso_oe),
		.pin_out(mux_out),
		.pin_oe(mux_oe)
	);
	logic active;
	assign active = next_state == BSMS_ST_SWPT || next_state == BSMS_ST_HWPT;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_out <= '0;
			pin_oe <= '0;
			pin_pu <= '0;
			pin_pd <= '1;
		end else if (next_state == BSMS_ST_SLEEP ||
			next_state == BSMS_ST_BOOT) begin
			// release all shared pins while asleep
			pin_out <= '0;
			pin_oe <= '0;
			pin_pu <= '0;
			pin_pd <= '1;
		end else if (active) begin
			// firmware pin config in active mode
			pin_out <= pin_cfg_out;
			pin_oe <= pin_cfg_dir;
			pin_pu <= pin_cfg_pu;
			pin_pd <= pin_cfg_pd & ~pin_cfg_pu;
		end else begin
			pin_out <= mux_out;
			pin_oe <= mux_oe;
			pin_pu <= '0;
			pin_pd <= '0;
		end
	end
	// *************************************************
	// checks
	// *************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_sleeping;
		state == BSMS_ST_SLEEP;
	endsequence
	sequence s_woken;
		state == BSMS_ST_SLEEP ##1 state != BSMS_ST_SLEEP;
	endsequence
	swpt_fw_a: assert property (sw_passthru |-> fw_loaded || $past(fw_loaded))
		else $error("sw pass-through without firmware");
	hwpt_fwd_a: assert property (state == BSMS_ST_HWPT && $past(state) ==
		BSMS_ST_HWPT |-> passthrough_bitstream_output ==
		$past(primary_mic_input_port))
		else $error("bypass output not following mic");
	sleep_fw_a: assert property ($rose(state == BSMS_ST_SLEEP) |->
		$past(fw_loaded))
		else $error("sleep entered before firmware");
	wake_exit_a: assert property (s_sleeping ##0 wake |=> state != BSMS_ST_SLEEP)
		else $error("wake did not end sleep");
	restart_pulse_a: assert property (s_woken |-> blocks_restart ##1
		!blocks_restart)
		else $error("no restart pulse after wake");
	addr_map_a: assert property (straps_valid && addr_strap == 2'b01 |->
		slave_addr == 7'h38)
		else $error("wrong slave address for straps");
	boot_auto_a: assert property ($rose(ready) |=> state == BSMS_ST_AUTODET)
		else $error("no auto-detect after boot");
	sleep_quiet_a: assert property (s_sleeping ##1 s_sleeping |-> pin_oe == '0)
		else $error("pins driven while asleep");
	strap_hold_a: assert property (straps_valid |=> $stable(boot_clock_strap)
		&& $stable(slave_addr))
		else $error("strap value changed after capture");
endmodule // bsms_ctrl

// File: core/bsms_pin_mux.sv
// shared pin function map per boot mode
`timescale 1ns/1ps
`include "bsms_regs.svh"
module bsms_pin_mux import bsms_pkg::*; (
	input wire bsms_boot_mode_t mode,
	input wire logic pdm_clk,
	input wire logic pdm_data_out,
	input wire logic i2s_ws,
	input wire logic i2s_bclk,
	input wire logic i2s_sdo,
	input wire logic i2c_scl_oe,
	input wire logic i2c_sda_oe,
	input wire logic uart_tx,
	input wire logic host_irq,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	output logic [`BSMS_NPINS-1:0] pin_out,
	output logic [`BSMS_NPINS-1:0] pin_oe
);
	always_comb begin
		pin_out = '0;
		pin_oe = '0;
		case (mode)
			BSMS_PDM_I2C: begin
				pin_out = {1'b0, 1'b0, 2'b00, pdm_data_out, pdm_clk};
				pin_oe = {i2c_sda_oe, i2c_scl_oe, 2'b00, 2'b11};
			end
			BSMS_PDM_UART: begin
				pin_out = {uart_tx, 1'b0, host_irq, 1'b0, pdm_data_out,
					pdm_clk};
				pin_oe = 6'h2B;
			end
			BSMS_PDM_SPI: begin
				pin_out = {2'b00, spi_miso, 1'b0, pdm_data_out, pdm_clk};
				pin_oe = {2'b00, spi_miso_oe, 3'b011};
			end
			BSMS_I2S_I2C: begin
				pin_out = {2'b00, i2s_sdo, 1'b0, i2s_bclk, i2s_ws};
				pin_oe = {i2c_sda_oe, i2c_scl_oe, 4'hB};
			end
			default: begin
				pin_out = {uart_tx, 1'b0, i2s_sdo, 1'b0, i2s_bclk, i2s_ws};
				pin_oe = 6'h2B;
			end
		endcase
	end
endmodule // bsms_pin_mux

// File: core/bsms_strap_latch.sv
// one-shot strap capture after reset release
`timescale 1ns/1ps
module bsms_strap_latch #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] value,
	output logic done
);
	// capture on first clock after release; held until next reset
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			value <= '0;
			done <= 1'b0;
		end else if (!done) begin
			value <= pin_in;
			done <= 1'b1;
		end
	end
endmodule // bsms_strap_latch

// File: pkg/bsms_pkg.sv
// types for the boot strap, mode and sleep controller
package bsms_pkg;
	typedef enum logic [2:0] {
		BSMS_PDM_I2C,
		BSMS_PDM_UART,
		BSMS_PDM_SPI,
		BSMS_I2S_I2C,
		BSMS_I2S_UART
	} bsms_boot_mode_t;
	typedef enum logic [2:0] {
		BSMS_ST_BOOT,
		BSMS_ST_AUTODET,
		BSMS_ST_IDLE,
		BSMS_ST_SWPT,
		BSMS_ST_HWPT,
		BSMS_ST_SLEEP
	} bsms_state_t;
endpackage

// File: pkg/bsms_regs.svh
// constants for the boot strap, mode and sleep controller
`ifndef BSMS_REGS_SVH
`define BSMS_REGS_SVH
`define BSMS_ADDR_00 7'h3E
`define BSMS_ADDR_01 7'h38
`define BSMS_ADDR_10 7'h3F
`define BSMS_ADDR_11 7'h39
`define BSMS_ADDR_RST 7'h3E
`define BSMS_BOOT_EXT 1'h0
`define BSMS_BOOT_OSC 1'h1
`define BSMS_SLEEP_USE 1'h1
`define BSMS_SLEEP_RET 1'h0
`define BSMS_NPINS 6
`define BSMS_DIR_RST 6'h00
`endif
